// file: i2c_slave_clock_sync_bench.sv
// Bench joining the slave controller and a remote master
// Assumes package, interface and both ends compiled first
`timescale 1ns/1ps
`include "i2cs_map.svh"
module i2c_slave_clock_sync_bench;
    import i2cs_pkg::*;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [7:0]  addr = 8'h00;
    logic [31:0] wdata = 32'h0;
    logic        wr = 1'b0;
    logic        rd = 1'b0;
    logic        go = 1'b0;
    logic        rw = 1'b0;
    logic [6:0]  taddr = 7'h00;
    logic [7:0]  tdata = 8'h00;
    logic [31:0] rdata;
    logic        irq;
    logic        busy;
    logic        done;
    logic        ack;
    logic [7:0]  mrd;
    logic        rd_d = 1'b0;
    logic [63:0] q[$];
    logic [9:0]  mq[$];
    logic [63:0] ent;
    logic [9:0]  ment;
    logic [31:0] pk;
    logic [6:0]  sa;
    logic [7:0]  b[5];
    int          num_errors = 0;
    int          checks = 0;
    int          seed = 56954;
    int          n;
    always #12.5 clk = ~clk;
    i2cs_if bus ();
    i2cs_dev i2cs_dev_inst (.CLK(clk), .NRST(nrst), .ADDR(addr), .WDATA(wdata), .WR(wr),
        .RD(rd), .RDATA(rdata), .IRQ(irq), .BUS(bus));
    i2cs_master i2cs_master_inst (.CLK(clk), .NRST(nrst), .GO(go), .TADDR(taddr), .RW(rw),
        .TDATA(tdata), .BUSY(busy), .DONE(done), .RDATA(mrd), .ACK(ack), .BUS(bus));
    i2cs_bus_checker i2cs_bus_checker_inst (.CLK(clk), .NRST(nrst), .scl_m_o(bus.scl_m_o),
        .scl_m_oe(bus.scl_m_oe), .sda_m_o(bus.sda_m_o), .sda_m_oe(bus.sda_m_oe),
        .scl_s_o(bus.scl_s_o), .scl_s_oe(bus.scl_s_oe), .sda_s_o(bus.sda_s_o),
        .sda_s_oe(bus.sda_s_oe), .scl(bus.scl), .sda(bus.sda));
    // ****************************************
    // Tasks
    // ****************************************
    task automatic check(input string nm, input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            num_errors++;
            $display("[FAIL] %s exp %h seen %h", nm, e, s);
        end
    endtask : check
    task automatic final_report();
        $display("checks %0d mismatches %0d", checks, num_errors);
        if (num_errors == 0 && checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report
    task automatic w(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask : w
    task automatic r(input logic [7:0] a, input logic [31:0] e, input logic [31:0] m);
        @(posedge clk);
        q.push_back({m, e});
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 pk = rdata;
    endtask : r
    task automatic mx(input logic [6:0] a, input logic d, input logic [7:0] t,
                      input logic [9:0] e);
        @(posedge clk);
        mq.push_back(e);
        taddr <= a;
        rw <= d;
        tdata <= t;
        go <= 1'b1;
        @(posedge clk);
        go <= 1'b0;
        for (int i = 0; i < 40000 && !done; i++) @(posedge clk);
        if (!done) begin
            num_errors++;
            final_report();
        end
        @(posedge clk);
        #1 check("busy", 32'(busy), 32'h0);
    endtask : mx
    // ****************************************
    // Result watcher
    // ****************************************
    always @(posedge clk) begin
        if (rd_d) begin
            ent = q.pop_front();
            check("rdata", rdata & ent[63:32], ent[31:0]);
        end
        if (done) begin
            ment = mq.pop_front();
            check("ack", 32'(ack), 32'(ment[8]));
            if (ment[9]) check("rbyte", 32'(mrd), 32'(ment[7:0]));
        end
        rd_d <= rd;
    end
    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        sa = {2'b01, 5'($random(seed))};
        foreach (b[i]) b[i] = 8'($random(seed));
        repeat (20) @(posedge clk);
        nrst <= 1'b1;
        r(8'h04, 32'(`I2CS_SAR_RST), '1);
        r(8'h30, 32'h0, '1);
        w(8'h04, 32'(sa));
        w(8'h08, 32'h1);
        w(8'h00, 32'h1);
        r(8'h00, 32'h0, '1);
        w(8'h14, 32'h4);
        mx(sa, 1'b0, b[0], 10'h100);
        r(8'h1c, 32'h8, 32'h8);
        r(8'h10, 32'h4, 32'h4);
        check("irq", 32'(irq), 32'h1);
        r(8'h0c, 32'(b[0]), 32'hff);
        mx(sa ^ 7'h01, 1'b0, b[1], 10'h000);
        $display("receive test done");
        for (int i = 0; i < 5; i++) mx(sa, 1'b0, b[i], 10'h100);
        r(8'h10, 32'h2, 32'h2);
        for (int i = 0; i < 4; i++) r(8'h0c, 32'(b[i]), 32'hff);
        $display("overflow test done");
        w(8'h0c, 32'h5a);
        pk = 0;
        fork
            mx(sa, 1'b1, 8'h00, {2'b11, b[4]});
            begin
                for (n = 0; n < 3000 && !pk[5]; n++) r(8'h10, 32'h0, 32'h0);
                check("flags", 32'(pk[6:5]), 32'h3);
                for (n = 0; n < 2000 && !bus.scl_s_oe; n++) @(posedge clk);
                repeat (400) @(posedge clk);
                check("hold", {bus.scl_s_oe, bus.scl}, 32'h2);
                r(8'h10, 32'h0, 32'h60);
                w(8'h0c, 32'(b[4]));
            end
        join
        $display("transmit test done");
        w(8'h08, 32'h0);
        w(8'h00, 32'h8);
        w(8'h08, 32'h1);
        r(8'h04, 32'(sa), '1);
        r(8'h00, 32'h8, '1);
        mx(sa, 1'b0, b[2], 10'h000);
        $display("address mode test done");
        repeat (4) @(posedge clk);
        final_report();
    end
endmodule : i2c_slave_clock_sync_bench

// file: i2cs_bus_checker.sv
// Checker for the two-wire bus between both ends
// Assumes the interface signals as plain inputs
`timescale 1ns/1ps
`include "i2cs_map.svh"
module i2cs_bus_checker (
    input wire logic CLK,
    input wire logic NRST,
    input wire logic scl_m_o,
    input wire logic scl_m_oe,
    input wire logic sda_m_o,
    input wire logic sda_m_oe,
    input wire logic scl_s_o,
    input wire logic scl_s_oe,
    input wire logic sda_s_o,
    input wire logic sda_s_oe,
    input wire logic scl,
    input wire logic sda
);
    localparam int LO = `I2CS_LOW_CYC;
    localparam int HI = `I2CS_HIGH_CYC;
    int lo_n;
    int hi_n;
    default clocking @(posedge CLK); endclocking
    default disable iff (!NRST);
    // ****************************************
    // Phase counters
    // ****************************************
    always_ff @(posedge CLK) begin
        lo_n <= (NRST && scl_m_oe) ? lo_n + 1 : 0;
    end
    always_ff @(posedge CLK) begin
        hi_n <= (NRST && scl) ? hi_n + 1 : 0;
    end
    // ****************************************
    // Assertions
    // ****************************************
    a_wired_scl: assert property (
        scl == !((scl_m_oe && !scl_m_o) || (scl_s_oe && !scl_s_o)))
        else $error("scl level wrong");
    a_master_pulls_low: assert property (scl_m_oe |-> !scl_m_o)
        else $error("master drives high");
    a_high_wait: assert property (!scl_m_oe && !scl |=> !scl_m_oe)
        else $error("master left high wait");
    a_low_count: assert property (
        $fell(scl_m_oe) |-> lo_n >= LO - 2 && lo_n <= LO + 2)
        else $error("low period wrong");
    a_high_count: assert property ($rose(scl_m_oe) |-> hi_n >= HI)
        else $error("high period short");
    a_rise_hold: assert property ($rose(scl) |-> (!scl_m_oe)[*8])
        else $error("master cut high early");
    a_stretch_low: assert property ($rose(scl_s_oe) |-> !scl)
        else $error("stretch began high");
    a_sda_low_clk: assert property ($changed(sda_s_oe) |-> !scl)
        else $error("slave sda moved in high");
    c_stretch: cover property ($rose(scl_s_oe));
    c_slave_sda: cover property ($fell(sda_s_oe));
    c_waited: cover property ($fell(scl_m_oe) && !scl);
endmodule : i2cs_bus_checker

// file: i2cs_dev.sv
// Slave end of the two-wire controller with its software register port
// Assumes a remote master on i2cs_if and software on the plain port
`timescale 1ns/1ps
module i2cs_dev
    import i2cs_pkg::*;
(
    input  wire logic        CLK,
    input  wire logic        NRST,
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    output logic             IRQ,
    i2cs_if.dev              BUS
);
    function automatic logic [2:0] lvl(input logic [2:0] wp, input logic [2:0] rp);
        return 3'(wp - rp);
    endfunction : lvl

    logic [6:0]  ctrl;
    logic [9:0]  sar;
    logic        en;
    logic [6:0]  mask;
    logic        active;
    logic        scl, sda, scl_q, sda_q;
    logic        re, fe, start, stop;
    i2cs_sst_e   st;
    logic [3:0]  cnt;
    logic [7:0]  sh;
    logic        sda_dr, scl_hold, rw, two, hit10;
    logic        rdreq_p, abrt_p, pop_p, push_p;
    logic [7:0]  rx_byte;
    logic [7:0]  txm [4];
    logic [7:0]  rxm [4];
    logic [2:0]  tx_wp, tx_rp, rx_wp, rx_rp, tx_lvl, rx_lvl;
    logic        rdreq_f, abrt_f, over_f, abrt_hold;
    logic        wr_tx, rd_rx, rd_raw, clr_rq, clr_ab, clr_ov;
    logic [6:0]  raw;

    // ****************************************
    // Bus sampling and conditions
    // ****************************************
    i2cs_sync #(.W(2)) u_sync (
        .CLK  (CLK),
        .NRST (NRST),
        .D    ({BUS.scl, BUS.sda}),
        .Q    ({scl, sda})
    );
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl;
            sda_q <= sda;
        end
    end
    assign re    = scl & ~scl_q;
    assign fe    = ~scl & scl_q;
    assign start = scl & scl_q & sda_q & ~sda;
    assign stop  = scl & scl_q & ~sda_q & sda;
    assign active = en & ~ctrl[`I2CS_CTRL_SLVDIS] & ~ctrl[`I2CS_CTRL_MASTER];

    // ****************************************
    // Software port decode
    // ****************************************
    assign tx_lvl = lvl(tx_wp, tx_rp);
    assign rx_lvl = lvl(rx_wp, rx_rp);
    assign wr_tx  = WR && ADDR == `I2CS_A_DATA && !WDATA[`I2CS_CMD_BIT] && active
                    && !abrt_hold && tx_lvl != `I2CS_DEPTH;
    assign rd_rx  = RD && ADDR == `I2CS_A_DATA && rx_lvl != 3'h0;
    assign rd_raw = RD && ADDR == `I2CS_A_RAW;
    assign clr_rq = (RD && ADDR == `I2CS_A_CLR_RDREQ)
                    || (rd_raw && !mask[`I2CS_EV_RDREQ]);
    assign clr_ab = (RD && ADDR == `I2CS_A_CLR_ABRT)
                    || (rd_raw && !mask[`I2CS_EV_ABRT]);

    assign clr_ov = RD && ADDR == `I2CS_A_CLR_OVER;

    always_comb begin
        raw = 7'h00;
        raw[`I2CS_EV_ABRT]   = abrt_f;
        raw[`I2CS_EV_RDREQ]  = rdreq_f;
        raw[`I2CS_EV_RXFULL] = rx_lvl != 3'h0;
        raw[`I2CS_EV_OVER]   = over_f;
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            ctrl <= `I2CS_CTRL_RST;
            sar  <= `I2CS_SAR_RST;
            en   <= 1'b0;
            mask <= `I2CS_MASK_RST;
        end else if (WR) begin
            if (ADDR == `I2CS_A_ENABLE) en <= WDATA[0];
            if (ADDR == `I2CS_A_MASK) mask <= WDATA[6:0];
            if (!en && ADDR == `I2CS_A_CTRL) ctrl <= WDATA[6:0];
            if (!en && ADDR == `I2CS_A_SAR) sar <= WDATA[9:0];
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) begin
            RDATA <= 32'h0;
        end else if (RD) begin
            unique case (ADDR)
                `I2CS_A_CTRL:   RDATA <= {25'h0, ctrl};
                `I2CS_A_SAR:    RDATA <= {22'h0, sar};
                `I2CS_A_ENABLE: RDATA <= {31'h0, en};
                `I2CS_A_DATA:   RDATA <= {24'h0, rxm[rx_rp[1:0]]};
                `I2CS_A_RAW:    RDATA <= {25'h0, raw};
                `I2CS_A_MASK:   RDATA <= {25'h0, mask};
                `I2CS_A_MSTAT:  RDATA <= {25'h0, raw & mask};
                `I2CS_A_STATUS: RDATA <= {28'h0, rx_lvl != 3'h0, tx_lvl == 3'h0,
                                          tx_lvl != `I2CS_DEPTH, st != S_IDLE};
                default:        RDATA <= 32'h0;
            endcase
        end else begin
            RDATA <= 32'h0;
        end
    end

    // ****************************************
    // Event flags, set wins over clear
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            rdreq_f   <= 1'b0;
            abrt_f    <= 1'b0;
            over_f    <= 1'b0;
            abrt_hold <= 1'b0;
            IRQ       <= 1'b0;
        end else begin
            rdreq_f   <= rdreq_p | (rdreq_f & ~clr_rq);
            abrt_f    <= abrt_p | (abrt_f & ~clr_ab);
            abrt_hold <= abrt_p | (abrt_hold & ~clr_ab);
            over_f    <= (push_p && rx_lvl == `I2CS_DEPTH) | (over_f & ~clr_ov);
            IRQ       <= |(raw & mask);
        end
    end

    // ****************************************
    // FIFOs
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST || !en || abrt_p || abrt_hold) begin
            tx_wp <= 3'h0;
            tx_rp <= 3'h0;
        end else begin
            if (wr_tx) tx_wp <= 3'(tx_wp + 3'h1);
            if (pop_p) tx_rp <= 3'(tx_rp + 3'h1);
        end
    end
    always_ff @(posedge CLK) begin
        if (wr_tx) txm[tx_wp[1:0]] <= WDATA[7:0];
        if (push_p && rx_lvl != `I2CS_DEPTH) rxm[rx_wp[1:0]] <= rx_byte;
    end
    always_ff @(posedge CLK) begin
        if (!NRST || !en) begin
            rx_wp <= 3'h0;
            rx_rp <= 3'h0;
        end else begin
            if (push_p && rx_lvl != `I2CS_DEPTH) rx_wp <= 3'(rx_wp + 3'h1);
            if (rd_rx) rx_rp <= 3'(rx_rp + 3'h1);
        end
    end

    // ****************************************
    // Slave protocol engine
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST || !active) begin
            st      <= S_IDLE;
            cnt     <= 4'h0;
            sh      <= 8'h00;
            sda_dr  <= 1'b0;
            rw      <= 1'b0;
            two     <= 1'b0;
            hit10   <= 1'b0;
            rx_byte <= 8'h00;
            rdreq_p <= 1'b0;
            abrt_p  <= 1'b0;
            pop_p   <= 1'b0;
            push_p  <= 1'b0;
        end else begin
            rdreq_p <= 1'b0;
            abrt_p  <= 1'b0;
            pop_p   <= 1'b0;
            push_p  <= 1'b0;
            if (start) begin
                st     <= S_ADDR;
                cnt    <= 4'h0;
                sda_dr <= 1'b0;
            end else if (stop) begin
                st     <= S_IDLE;
                sda_dr <= 1'b0;
                hit10  <= 1'b0;
            end else if (re) begin
                if (cnt != 4'h8) cnt <= 4'(cnt + 4'h1);
                if (st != S_TXB) sh <= {sh[6:0], sda};
            end else if (fe) begin
                unique case (st)
                    S_ADDR: if (cnt == 4'h8) begin
                        if ((!ctrl[`I2CS_CTRL_ADDR10] && sh[7:1] == sar[6:0])
                            || (ctrl[`I2CS_CTRL_ADDR10] && sh[7:3] == `I2CS_TEN_HDR
                                && sh[2:1] == sar[9:8] && (!sh[0] || hit10))) begin
                            sda_dr <= 1'b1;
                            rw     <= sh[0];
                            two    <= ctrl[`I2CS_CTRL_ADDR10] && !sh[0];
                            st     <= S_AACK;
                            if (sh[0]) begin
                                rdreq_p <= 1'b1;
                                if (tx_lvl != 3'h0) abrt_p <= 1'b1;
                            end
                        end else begin
                            st <= S_IDLE;
                        end
                    end
                    S_ADDR2: if (cnt == 4'h8) begin
                        if (sh == sar[7:0]) begin
                            sda_dr <= 1'b1;
                            hit10  <= 1'b1;
                            two    <= 1'b0;
                            st     <= S_AACK;
                        end else begin
                            st <= S_IDLE;
                        end
                    end
                    S_AACK: begin
                        sda_dr <= 1'b0;
                        cnt    <= 4'h0;
                        st     <= two ? S_ADDR2 : (rw ? S_WTX : S_RXB);
                    end
                    S_TXB: if (cnt == 4'h8) begin
                        sda_dr <= 1'b0;
                        cnt    <= 4'h0;
                        st     <= S_TXA;
                    end else begin
                        sh     <= {sh[6:0], 1'b0};
                        sda_dr <= ~sh[6];
                    end
                    S_TXA: if (!sh[0]) begin
                        st <= S_WTX;
                        if (tx_lvl == 3'h0) rdreq_p <= 1'b1;
                    end else begin
                        st <= S_IDLE;
                        if (tx_lvl != 3'h0) abrt_p <= 1'b1;
                    end
                    S_RXB: if (cnt == 4'h8) begin
                        push_p  <= 1'b1;
                        rx_byte <= sh;
                        sda_dr  <= 1'b1;
                        st      <= S_RACK;
                    end
                    S_RACK: begin
                        sda_dr <= 1'b0;
                        cnt    <= 4'h0;
                        st     <= S_RXB;
                    end
                    default: ;
                endcase
            end else if (st == S_WTX && tx_lvl != 3'h0 && !abrt_hold) begin
                sh     <= txm[tx_rp[1:0]];
                sda_dr <= ~txm[tx_rp[1:0]][7];
                pop_p  <= 1'b1;
                cnt    <= 4'h0;
                st     <= S_TXB;
            end
        end
    end

    always_ff @(posedge CLK) begin
        if (!NRST) scl_hold <= 1'b0;
        else       scl_hold <= active && st == S_WTX;
    end

    assign BUS.scl_s_o  = 1'b0;
    assign BUS.scl_s_oe = scl_hold;
    assign BUS.sda_s_o  = 1'b0;
    assign BUS.sda_s_oe = sda_dr;
endmodule : i2cs_dev

// file: i2cs_if.sv
// Open-drain two-wire bus joining the controller and a remote master
// Assumes each end drives only its own enables; levels are wired-AND
`timescale 1ns/1ps
interface i2cs_if;
    logic scl_m_o;
    logic scl_m_oe;
    logic sda_m_o;
    logic sda_m_oe;
    logic scl_s_o;
    logic scl_s_oe;
    logic sda_s_o;
    logic sda_s_oe;
    logic scl;
    logic sda;
    assign scl = (scl_m_oe ? scl_m_o : 1'b1) & (scl_s_oe ? scl_s_o : 1'b1);
    assign sda = (sda_m_oe ? sda_m_o : 1'b1) & (sda_s_oe ? sda_s_o : 1'b1);
    modport dev (input scl, sda, output scl_s_o, scl_s_oe, sda_s_o, sda_s_oe);
    modport mst (input scl, sda, output scl_m_o, scl_m_oe, sda_m_o, sda_m_oe);
endinterface : i2cs_if

// file: i2cs_map.svh
// Register offsets, field positions, reset values and timing counts
// Assumes inclusion by the package and design files by bare name
`ifndef I2CS_MAP_SVH
`define I2CS_MAP_SVH
// ****************************************
// Register offsets
// ****************************************
`define I2CS_A_CTRL      8'h00
`define I2CS_A_SAR       8'h04
`define I2CS_A_ENABLE    8'h08
`define I2CS_A_DATA      8'h0c
`define I2CS_A_RAW       8'h10
`define I2CS_A_MASK      8'h14
`define I2CS_A_MSTAT     8'h18
`define I2CS_A_STATUS    8'h1c
`define I2CS_A_CLR_RDREQ 8'h20
`define I2CS_A_CLR_ABRT  8'h24
`define I2CS_A_CLR_OVER  8'h28
// ****************************************
// Fields and reset values
// ****************************************
`define I2CS_CTRL_MASTER 0
`define I2CS_CTRL_ADDR10 3
`define I2CS_CTRL_SLVDIS 6
`define I2CS_CMD_BIT     8
`define I2CS_EV_OVER     1
`define I2CS_EV_RXFULL   2
`define I2CS_EV_RDREQ    5
`define I2CS_EV_ABRT     6
`define I2CS_ST_ACT      0
`define I2CS_ST_TFNF     1
`define I2CS_ST_TFE      2
`define I2CS_ST_RECEIVE_FIFO_NONEMPTY     3
`define I2CS_CTRL_RST    7'h00
`define I2CS_SAR_RST     10'h055
`define I2CS_MASK_RST    7'h00
`define I2CS_TEN_HDR     5'h1e
`define I2CS_DEPTH       3'h4
// ****************************************
// Timing
// ****************************************
`define I2CS_CLK_MHZ     40
`define I2CS_T_LOW_NS    4700
`define I2CS_T_HIGH_NS   4000
`define I2CS_LOW_CYC     ((`I2CS_T_LOW_NS * `I2CS_CLK_MHZ + 999) / 1000)
`define I2CS_HIGH_CYC    ((`I2CS_T_HIGH_NS * `I2CS_CLK_MHZ + 999) / 1000)
`define I2CS_SETUP_CYC   8'h02
`endif

// file: i2cs_master.sv
// Remote master end: one address byte and one data byte per request
// Assumes an idle bus at each request and clock-stretching slaves
`timescale 1ns/1ps
module i2cs_master
    import i2cs_pkg::*;
(
    input  wire logic       CLK,
    input  wire logic       NRST,
    input  wire logic       GO,
    input  wire logic [6:0] TADDR,
    input  wire logic       RW,
    input  wire logic [7:0] TDATA,
    output logic            BUSY,
    output logic            DONE,
    output logic [7:0]      RDATA,
    output logic            ACK,
    i2cs_if.mst             BUS
);
    localparam logic [7:0] LOW_END  = 8'(`I2CS_LOW_CYC - 1);
    localparam logic [7:0] HIGH_END = 8'(`I2CS_HIGH_CYC - 1);

    i2cs_mst_e   st;
    i2cs_ph_e    ph;
    logic [7:0]  cnt;
    logic [4:0]  idx;
    logic [17:0] seq, samp;
    logic        scl, sda, scl_dr, sda_dr, rw_l;

    i2cs_sync #(.W(2)) u_sync (
        .CLK  (CLK),
        .NRST (NRST),
        .D    ({BUS.scl, BUS.sda}),
        .Q    ({scl, sda})
    );

    // ****************************************
    // Clock generation and bit sequencing
    // ****************************************
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            st     <= M_IDLE;
            ph     <= P_LOW;
            cnt    <= 8'h00;
            idx    <= 5'h00;
            seq    <= 18'h3ffff;
            samp   <= 18'h3ffff;
            scl_dr <= 1'b0;
            sda_dr <= 1'b0;
            rw_l   <= 1'b0;
            DONE   <= 1'b0;
            RDATA  <= 8'h00;
            ACK    <= 1'b0;
        end else begin
            DONE <= 1'b0;
            unique case (st)
                M_IDLE: if (GO) begin
                    seq    <= {TADDR, RW, 1'b1, RW ? 8'hff : TDATA, 1'b1};
                    rw_l   <= RW;
                    sda_dr <= 1'b1;
                    cnt    <= 8'h00;
                    st     <= M_START;
                end
                M_START: begin
                    cnt <= 8'(cnt + 8'h01);
                    if (cnt == HIGH_END) begin
                        st     <= M_BITS;
                        ph     <= P_LOW;
                        cnt    <= 8'h00;
                        idx    <= 5'h00;
                        scl_dr <= 1'b1;
                    end
                end
                M_BITS, M_STOP: begin
                    unique case (ph)
                        P_LOW: begin
                            cnt <= 8'(cnt + 8'h01);
                            if (cnt == `I2CS_SETUP_CYC)
                                sda_dr <= (st == M_STOP) ? 1'b1 : ~seq[17];
                            if (cnt == LOW_END) begin
                                scl_dr <= 1'b0;
                                ph     <= P_HWAIT;
                            end
                        end
                        P_HWAIT: if (scl) begin
                            ph  <= P_HIGH;
                            cnt <= 8'h00;
                            if (st == M_BITS) samp <= {samp[16:0], sda};
                        end
                        P_HIGH: begin
                            cnt <= 8'(cnt + 8'h01);
                            if (cnt == HIGH_END || !scl) begin
                                cnt <= 8'h00;
                                if (st == M_STOP) begin
                                    sda_dr <= 1'b0;
                                    st     <= M_IDLE;
                                    ph     <= P_LOW;
                                    DONE   <= 1'b1;
                                    RDATA  <= samp[8:1];
                                    ACK    <= ~samp[9] & (rw_l | ~samp[0]);
                                end else begin
                                    scl_dr <= 1'b1;
                                    ph     <= P_LOW;
                                    seq    <= {seq[16:0], 1'b1};
                                    if (idx == 5'd17) st <= M_STOP;
                                    else idx <= 5'(idx + 5'h01);
                                end
                            end
                        end
                        default: ph <= P_LOW;
                    endcase
                end
                default: st <= M_IDLE;
            endcase
        end
    end

    assign BUSY         = st != M_IDLE;
    assign BUS.scl_m_o  = 1'b0;
    assign BUS.scl_m_oe = scl_dr;
    assign BUS.sda_m_o  = 1'b0;
    assign BUS.sda_m_oe = sda_dr;
endmodule : i2cs_master

// file: i2cs_pkg.sv
// Types shared by both ends of the two-wire link
// Assumes i2cs_map.svh is on the include path
package i2cs_pkg;
    `include "i2cs_map.svh"
    typedef enum logic [3:0] {
        S_IDLE  = 4'h0,
        S_ADDR  = 4'h1,
        S_ADDR2 = 4'h2,
        S_AACK  = 4'h3,
        S_WTX   = 4'h4,
        S_TXB   = 4'h5,
        S_TXA   = 4'h6,
        S_RXB   = 4'h7,
        S_RACK  = 4'h8
    } i2cs_sst_e;
    typedef enum logic [1:0] {
        M_IDLE  = 2'h0,
        M_START = 2'h1,
        M_BITS  = 2'h2,
        M_STOP  = 2'h3
    } i2cs_mst_e;
    typedef enum logic [1:0] {
        P_LOW   = 2'h0,
        P_HWAIT = 2'h1,
        P_HIGH  = 2'h2
    } i2cs_ph_e;
endpackage : i2cs_pkg

// file: i2cs_sync.sv
// Two-flop synchroniser for bus levels
// Assumes inputs asynchronous to CLK
`timescale 1ns/1ps
module i2cs_sync #(
    parameter int W = 2
) (
    input  wire logic         CLK,
    input  wire logic         NRST,
    input  wire logic [W-1:0] D,
    output logic      [W-1:0] Q
);
    logic [W-1:0] meta;
    always_ff @(posedge CLK) begin
        if (!NRST) begin
            meta <= '1;
            Q    <= '1;
        end else begin
            meta <= D;
            Q    <= meta;
        end
    end
endmodule : i2cs_sync
